// >>> inc/sfc_consts.vh
// Constants for the serial flash command decoder: opcodes, command classes,
// shift counts and reset values. Included by the decoder only.
//
// What this block does
// - Pause pin low floats serial output immediately
// - Serial input ignored while clock and pause low
// - Chip select high during pause abandons transaction
// - Pause disabled in four-lane mode
// - Maker-part read: 00 maker first, 01 device
// - 06 sets latch, 04 clears, 01 writes status
// - 9F returns maker plus two device bytes; 05 status
// - 03 reads stream; 0B adds one dummy byte
// - 5A parameter table, 3B two-lane stream
// - AB: legacy id, also sleep exit; 90 ids
// - 20 sector, 52/D8 block, 60/C7 whole-array wipe
// - 02 page write, 2B security read, 2F lock
// - B1/C1 secure area enter/leave, B9 sleep
// - Sample on rising clock, shift out falling
// - Write-type commands need select rise on byte boundary
// - Pause starts and ends only while clock low
// - Unknown command: standby, output floated until select rises
`ifndef SFC_CONSTS_VH
`define SFC_CONSTS_VH

// ---------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------
`define SFC_OP_WRITE_UNLOCK 8'h06
`define SFC_OP_WRITE_LOCK 8'h04
`define SFC_OP_STATUS_WRITE 8'h01
`define SFC_OP_IDENT_READ 8'h9f
`define SFC_OP_STATUS_READ 8'h05
`define SFC_OP_READ 8'h03
`define SFC_OP_FAST_READ 8'h0b
`define SFC_OP_PARAM_TABLE_READ 8'h5a
`define SFC_OP_LEGACY_ID_READ 8'hab
`define SFC_OP_MAKER_PART_ID_READ 8'h90
`define SFC_OP_TWO_LANE_READ 8'h3b
`define SFC_OP_SMALL_REGION_WIPE 8'h20
`define SFC_OP_LARGE_REGION_WIPE_A 8'h52
`define SFC_OP_LARGE_REGION_WIPE_B 8'hd8
`define SFC_OP_ALL_WIPE_A 8'h60
`define SFC_OP_ALL_WIPE_B 8'hc7
`define SFC_OP_PAGE_WRITE 8'h02
`define SFC_OP_SECURITY_WORD_READ 8'h2b
`define SFC_OP_SECURITY_LOCK_WRITE 8'h2f
`define SFC_OP_SECURE_AREA_ENTER 8'hb1
`define SFC_OP_SECURE_AREA_LEAVE 8'hc1
`define SFC_OP_SLEEP_ENTRY 8'hb9

// ---------------------------------------------------------------
// Command classes
// ---------------------------------------------------------------
`define SFC_CL_BAD 3'd0
`define SFC_CL_ACT 3'd1
`define SFC_CL_OUT 3'd2
`define SFC_CL_ADDR_OUT 3'd3
`define SFC_CL_ADDR_DUMMY 3'd4
`define SFC_CL_ADDR_ACT 3'd5
`define SFC_CL_DATA_IN 3'd6
`define SFC_CL_ADDR_IN 3'd7

// ---------------------------------------------------------------
// Counts, positions and reset values
// ---------------------------------------------------------------
`define SFC_BIT_LAST 3'd7
`define SFC_BIT_FIRST 3'd0
`define SFC_BIT_ONE 3'd1
`define SFC_BIT_TWO 3'd2
`define SFC_ADDR_LAST 2'd2
`define SFC_IDENT_LAST 2'd2
`define SFC_SR_LATCH_BIT 1
`define SFC_BYTE_ZERO 8'h00
`define SFC_ADDR_ZERO 24'h000000
`define SFC_ADDR_STEP 24'h000001

`endif

// >>> src/sfc_cmd_decode.v
// Serial flash command decoder with pause handling and one/two-lane output.
// Assumes pins arrive asynchronous to ref_clk, serial clock well below
// ref_clk/4, and array/parameter data answered one cycle after rd_req.
`timescale 1ns/10ps
`include "sfc_consts.vh"

module sfc_cmd_decode #(
    parameter [7:0] MAKER_CODE = 8'h5c, // Arbitrary identity value
    parameter [7:0] DEVICE_HI = 8'h21, // Arbitrary identity value
    parameter [7:0] DEVICE_LO = 8'h3e, // Arbitrary identity value
    parameter [7:0] LEGACY_CODE = 8'h47 // Arbitrary identity value
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Serial pins
    input wire cs_b,
    input wire sclk,
    input wire si_in,
    input wire hold_b,
    output reg si_out,
    output reg si_oe,
    output reg so_out,
    output reg so_oe,
    // Device state
    input wire quad_mode,
    input wire [7:0] status_in,
    input wire [7:0] security_in,
    input wire [7:0] rd_data,
    // Array access
    output reg rd_req,
    output reg param_sel,
    output reg [23:0] mem_addr,
    output reg [7:0] wr_data,
    output reg wr_strobe,
    // Command events
    output reg status_write,
    output reg page_write,
    output reg small_region_wipe,
    output reg large_region_wipe,
    output reg all_wipe,
    output reg security_lock_write,
    // Mode flags
    output reg write_latch_flag,
    output reg secure_area,
    output reg sleeping
);

// ---------------------------------------------------------------
// States
// ---------------------------------------------------------------
localparam [2:0] ST_OP = 3'd0;
localparam [2:0] ST_ADDR = 3'd1;
localparam [2:0] ST_DUMMY = 3'd2;
localparam [2:0] ST_OUT = 3'd3;
localparam [2:0] ST_IN = 3'd4;
localparam [2:0] ST_DONE = 3'd5;
localparam [2:0] ST_STBY = 3'd6;

// ---------------------------------------------------------------
// Decoding helpers
// ---------------------------------------------------------------
// Classify an opcode by the phases that follow it
function [2:0] op_class;
    input [7:0] op;
    begin
        case (op)
            `SFC_OP_WRITE_UNLOCK, `SFC_OP_WRITE_LOCK, `SFC_OP_ALL_WIPE_A,
            `SFC_OP_ALL_WIPE_B, `SFC_OP_SECURITY_LOCK_WRITE, `SFC_OP_SECURE_AREA_ENTER,
            `SFC_OP_SECURE_AREA_LEAVE, `SFC_OP_SLEEP_ENTRY: op_class = `SFC_CL_ACT;
            `SFC_OP_IDENT_READ, `SFC_OP_STATUS_READ,
            `SFC_OP_SECURITY_WORD_READ: op_class = `SFC_CL_OUT;
            `SFC_OP_READ, `SFC_OP_LEGACY_ID_READ,
            `SFC_OP_MAKER_PART_ID_READ: op_class = `SFC_CL_ADDR_OUT;
            `SFC_OP_FAST_READ, `SFC_OP_PARAM_TABLE_READ,
            `SFC_OP_TWO_LANE_READ: op_class = `SFC_CL_ADDR_DUMMY;
            `SFC_OP_SMALL_REGION_WIPE, `SFC_OP_LARGE_REGION_WIPE_A,
            `SFC_OP_LARGE_REGION_WIPE_B: op_class = `SFC_CL_ADDR_ACT;
            `SFC_OP_STATUS_WRITE: op_class = `SFC_CL_DATA_IN;
            `SFC_OP_PAGE_WRITE: op_class = `SFC_CL_ADDR_IN;
            default: op_class = `SFC_CL_BAD;
        endcase
    end
endfunction

// Opcodes whose output comes from the array or parameter table
function is_array_read;
    input [7:0] op;
    begin
        is_array_read = (op == `SFC_OP_READ) || (op == `SFC_OP_FAST_READ) ||
                        (op == `SFC_OP_TWO_LANE_READ) || (op == `SFC_OP_PARAM_TABLE_READ);
    end
endfunction

// ---------------------------------------------------------------
// Pin synchronisers and edge detect
// ---------------------------------------------------------------
reg [3:0] sync_m;
reg [3:0] sync_s;
reg cs_d;
reg sclk_d;
wire cs_s = sync_s[0];
wire sclk_s = sync_s[1];
wire si_s = sync_s[2];
wire hold_s = sync_s[3];

// Two flip-flops per pin: {hold, si, sclk, cs}
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        sync_m <= 4'h9;
        sync_s <= 4'h9;
        cs_d <= 1'b1;
        sclk_d <= 1'b0;
    end else begin
        sync_m <= {hold_b, si_in, sclk, cs_b};
        sync_s <= sync_m;
        cs_d <= cs_s;
        sclk_d <= sclk_s;
    end
end

wire cs_rise = cs_s & ~cs_d;
wire sclk_rise = sclk_s & ~sclk_d;
wire sclk_fall = ~sclk_s & sclk_d;

// ---------------------------------------------------------------
// Pause tracking
// ---------------------------------------------------------------
reg hold_on;
wire hold_active = ~quad_mode & hold_on;
wire out_block = ~quad_mode & (~hold_s | hold_on);

// Pause follows the pin only while the serial clock is low
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        hold_on <= 1'b0;
    end else if (cs_s) begin
        hold_on <= 1'b0;
    end else if (!sclk_s) begin
        hold_on <= ~hold_s;
    end
end

wire take_in = sclk_rise & ~cs_s & ~hold_active;
wire take_out = sclk_fall & ~cs_s & ~hold_active;

// ---------------------------------------------------------------
// Command sequencer
// ---------------------------------------------------------------
reg [2:0] state;
reg [2:0] bit_cnt;
reg [1:0] byte_cnt;
reg [6:0] shift;
reg [7:0] opcode;
reg [23:0] addr;
reg got_data;
reg [2:0] out_bit;
reg out_first;
reg [7:0] cur;
reg [1:0] out_idx;
reg drive;
wire [7:0] in_byte = {shift, si_s};
wire [2:0] cls = op_class(opcode);
wire dual = (opcode == `SFC_OP_TWO_LANE_READ);
wire last_bit = (bit_cnt == `SFC_BIT_LAST);
wire on_boundary = (bit_cnt == `SFC_BIT_FIRST);

// Source of the next output byte
reg [7:0] src;
always @* begin
    case (opcode)
        `SFC_OP_IDENT_READ: begin
            case (out_idx)
                2'd0: src = MAKER_CODE;
                2'd1: src = DEVICE_HI;
                default: src = DEVICE_LO;
            endcase
        end
        `SFC_OP_STATUS_READ: begin
            src = status_in;
            src[`SFC_SR_LATCH_BIT] = write_latch_flag;
        end
        `SFC_OP_SECURITY_WORD_READ: src = security_in;
        `SFC_OP_LEGACY_ID_READ: src = LEGACY_CODE;
        `SFC_OP_MAKER_PART_ID_READ: src = (addr[0] ^ out_idx[0]) ? DEVICE_HI : MAKER_CODE;
        default: src = rd_data;
    endcase
end

wire [7:0] out_byte = out_first ? src : cur;

// Main sequencer: opcode, address, dummy, data in, data out, standby
always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
        state <= ST_OP;
        bit_cnt <= `SFC_BIT_FIRST;
        byte_cnt <= 2'd0;
        shift <= 7'h00;
        opcode <= `SFC_BYTE_ZERO;
        addr <= `SFC_ADDR_ZERO;
        got_data <= 1'b0;
        out_bit <= `SFC_BIT_LAST;
        out_first <= 1'b1;
        cur <= `SFC_BYTE_ZERO;
        out_idx <= 2'd0;
        drive <= 1'b0;
        rd_req <= 1'b0;
        param_sel <= 1'b0;
        mem_addr <= `SFC_ADDR_ZERO;
        wr_data <= `SFC_BYTE_ZERO;
        wr_strobe <= 1'b0;
        status_write <= 1'b0;
        page_write <= 1'b0;
        small_region_wipe <= 1'b0;
        large_region_wipe <= 1'b0;
        all_wipe <= 1'b0;
        security_lock_write <= 1'b0;
        write_latch_flag <= 1'b0;
        secure_area <= 1'b0;
        sleeping <= 1'b0;
        si_out <= 1'b0;
        so_out <= 1'b0;
        si_oe <= 1'b0;
        so_oe <= 1'b0;
    end else begin
        rd_req <= 1'b0;
        wr_strobe <= 1'b0;
        status_write <= 1'b0;
        page_write <= 1'b0;
        small_region_wipe <= 1'b0;
        large_region_wipe <= 1'b0;
        all_wipe <= 1'b0;
        security_lock_write <= 1'b0;
        // Select rise: commit write-type commands on a clean byte boundary
        if (cs_rise && on_boundary && !hold_active) begin
            if (state == ST_DONE) begin
                case (opcode)
                    `SFC_OP_WRITE_UNLOCK: write_latch_flag <= 1'b1;
                    `SFC_OP_WRITE_LOCK: write_latch_flag <= 1'b0;
                    `SFC_OP_SMALL_REGION_WIPE: small_region_wipe <= 1'b1;
                    `SFC_OP_LARGE_REGION_WIPE_A,
                    `SFC_OP_LARGE_REGION_WIPE_B: large_region_wipe <= 1'b1;
                    `SFC_OP_ALL_WIPE_A, `SFC_OP_ALL_WIPE_B: all_wipe <= 1'b1;
                    `SFC_OP_SECURITY_LOCK_WRITE: security_lock_write <= 1'b1;
                    `SFC_OP_SECURE_AREA_ENTER: secure_area <= 1'b1;
                    `SFC_OP_SECURE_AREA_LEAVE: secure_area <= 1'b0;
                    `SFC_OP_SLEEP_ENTRY: sleeping <= 1'b1;
                    default: ;
                endcase
            end
            if (state == ST_IN && got_data) begin
                status_write <= (opcode == `SFC_OP_STATUS_WRITE);
                page_write <= (opcode == `SFC_OP_PAGE_WRITE);
            end
            if (state != ST_OP && state != ST_STBY && opcode == `SFC_OP_LEGACY_ID_READ)
                sleeping <= 1'b0;
        end
        if (cs_s) begin
            // Deselected: state, counters and output drive return to idle; opcode and address keep their values
            state <= ST_OP;
            bit_cnt <= `SFC_BIT_FIRST;
            byte_cnt <= 2'd0;
            got_data <= 1'b0;
            out_bit <= `SFC_BIT_LAST;
            out_first <= 1'b1;
            out_idx <= 2'd0;
            drive <= 1'b0;
            param_sel <= 1'b0;
        end else begin
            if (take_in && state != ST_STBY && state != ST_OUT) begin
                shift <= in_byte[6:0];
                bit_cnt <= bit_cnt + `SFC_BIT_ONE;
                if (last_bit) begin
                    case (state)
                        ST_OP: begin
                            opcode <= in_byte;
                            if (sleeping && in_byte != `SFC_OP_LEGACY_ID_READ)
                                state <= ST_STBY;
                            else begin
                                case (op_class(in_byte))
                                    `SFC_CL_BAD: state <= ST_STBY;
                                    `SFC_CL_ACT: state <= ST_DONE;
                                    `SFC_CL_OUT: state <= ST_OUT;
                                    `SFC_CL_DATA_IN: state <= ST_IN;
                                    default: state <= ST_ADDR;
                                endcase
                            end
                        end
                        ST_ADDR: begin
                            addr <= {addr[15:0], in_byte};
                            byte_cnt <= byte_cnt + 2'd1;
                            if (byte_cnt == `SFC_ADDR_LAST) begin
                                mem_addr <= {addr[15:0], in_byte};
                                param_sel <= (opcode == `SFC_OP_PARAM_TABLE_READ);
                                rd_req <= (opcode == `SFC_OP_READ);
                                case (cls)
                                    `SFC_CL_ADDR_OUT: state <= ST_OUT;
                                    `SFC_CL_ADDR_DUMMY: state <= ST_DUMMY;
                                    `SFC_CL_ADDR_ACT: state <= ST_DONE;
                                    default: state <= ST_IN;
                                endcase
                            end
                        end
                        ST_DUMMY: begin
                            rd_req <= 1'b1;
                            state <= ST_OUT;
                        end
                        ST_IN: begin
                            wr_data <= in_byte;
                            wr_strobe <= 1'b1;
                            got_data <= 1'b1;
                        end
                        default: ;
                    endcase
                end
            end
            // Output phase: bits leave on falling serial clock edges
            if (take_out && state == ST_OUT) begin
                drive <= 1'b1;
                if (out_first) begin
                    cur <= src;
                    out_idx <= (out_idx == `SFC_IDENT_LAST) ? 2'd0 : out_idx + 2'd1;
                    if (is_array_read(opcode)) begin
                        mem_addr <= mem_addr + `SFC_ADDR_STEP;
                        rd_req <= 1'b1;
                    end
                end
                so_out <= out_byte[out_bit];
                if (dual) begin
                    si_out <= out_byte[out_bit - `SFC_BIT_ONE];
                    out_first <= (out_bit == `SFC_BIT_ONE);
                    out_bit <= (out_bit == `SFC_BIT_ONE) ? `SFC_BIT_LAST
                                                       : out_bit - `SFC_BIT_TWO;
                end else begin
                    out_first <= (out_bit == `SFC_BIT_FIRST);
                    out_bit <= out_bit - `SFC_BIT_ONE;
                end
            end
        end
        // Output enables: float in standby, on deselect and at once on pause
        so_oe <= ~cs_s & drive & (state == ST_OUT) & ~out_block;
        si_oe <= ~cs_s & drive & (state == ST_OUT) & dual & ~out_block;
    end
end

endmodule // sfc_cmd_decode

// >>> testbench/sfc_cmd_decode_assertions.sv
// Port-level checks of the serial flash command decoder.
// Sees only decoder ports; bound in below the module.
`timescale 1ns/10ps
module sfc_cmd_decode_chk (
    // Clock and reset
    input wire ref_clk,
    input wire rst_b,
    // Pins
    input wire cs_b,
    input wire hold_b,
    input wire so_oe,
    input wire si_oe,
    input wire quad_mode,
    // Events and modes
    input wire status_write,
    input wire page_write,
    input wire small_region_wipe,
    input wire large_region_wipe,
    input wire all_wipe,
    input wire security_lock_write,
    input wire write_latch_flag,
    input wire secure_area,
    input wire sleeping
);
    // ----
    // Checks
    // ----
    wire [5:0] ev = {status_write, page_write, small_region_wipe,
        large_region_wipe, all_wipe, security_lock_write};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    hold_float_a: assert property ((!hold_b && !quad_mode)[*6] |-> !so_oe && !si_oe)
        else $error("output driven in pause");
    cs_float_a: assert property (so_oe || si_oe |-> !$past(cs_b, 5))
        else $error("output driven when deselected");
    dual_both_a: assert property (si_oe |-> so_oe)
        else $error("two-lane output on one lane");
    ev_single_a: assert property ($onehot0(ev))
        else $error("two command pulses at once");
    ev_pulse_a: assert property (|ev |=> !(|ev))
        else $error("command pulse too long");
    ev_cs_a: assert property (|ev |-> cs_b && $past(cs_b, 2))
        else $error("command pulse before deselect");
    latch_rise_a: assert property ($rose(write_latch_flag) |-> cs_b)
        else $error("latch set inside frame");
    mode_move_a: assert property ($changed({secure_area, sleeping}) |-> cs_b)
        else $error("mode changed inside frame");
    cover property (si_oe);
    cover property (all_wipe);
    cover property ($fell(so_oe) && !cs_b);
endmodule // sfc_cmd_decode_chk

bind sfc_cmd_decode sfc_cmd_decode_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .cs_b(cs_b), .hold_b(hold_b), .so_oe(so_oe), .si_oe(si_oe), .quad_mode(quad_mode),
    .status_write(status_write), .page_write(page_write),
    .small_region_wipe(small_region_wipe), .large_region_wipe(large_region_wipe),
    .all_wipe(all_wipe), .security_lock_write(security_lock_write),
    .write_latch_flag(write_latch_flag), .secure_area(secure_area), .sleeping(sleeping));

// >>> testbench/sfc_host_model.sv
// Host serial master model, clock mode 0, 64 ns link clock.
// Tasks are called one at a time; pins move only at ref_clk falls.
`timescale 1ns/10ps
module sfc_host_model (
    // Clock
    input wire ref_clk,
    // Pins toward the device
    output logic cs_b,
    output logic sclk,
    output logic host_si,
    output logic hold_b,
    // Pins from the device
    input wire so_out,
    input wire so_oe,
    input wire si_out
);
    // ----
    // Link sequencing
    // ----
    localparam int HALF = 4; // Half link period in ref cycles
    initial begin
        cs_b = 1'b1;
        sclk = 1'b0;
        host_si = 1'b0;
        hold_b = 1'b1;
    end
    // Wait n reference cycles
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // One clock pulse; clock stands low outside it
    task automatic pulse();
        tick(HALF);
        sclk = 1'b1;
        tick(HALF);
        sclk = 1'b0;
    endtask
    // Shift bits msb first, data changed while clock low
    task automatic send(input int n, input logic [31:0] v);
        for (int i = n - 1; i >= 0; i--) begin
            host_si = v[i];
            pulse();
        end
    endtask
    // Collect one byte; in one-lane mode an undriven line reads as alternating
    task automatic recv(input bit dual, output logic [7:0] r);
        r = 8'h00;
        for (int i = 0; i < (dual ? 4 : 8); i++) begin
            host_si = ~host_si;
            pulse();
            if (dual)
                r = {r[5:0], so_out, si_out};
            else
                r = {r[6:0], so_oe ? so_out : ~r[0]};
        end
    endtask
    // Select with the pause released
    task automatic open_frame();
        hold_b = 1'b1;
        cs_b = 1'b0;
        tick(HALF);
    endtask
    // Deselect wherever the bit count stands; callers choose on or off a byte boundary
    task automatic close_frame();
        tick(HALF);
        cs_b = 1'b1;
        host_si = ~host_si;
        tick(4 * HALF);
    endtask
    // Pause with clock low, then stray pulses
    task automatic pause(input int n);
        hold_b = 1'b0;
        tick(HALF);
        repeat (n) begin
            host_si = ~host_si;
            pulse();
        end
    endtask
    // End the pause, select still low
    task automatic resume();
        hold_b = 1'b1;
        tick(HALF);
    endtask
endmodule // sfc_host_model

// >>> testbench/test_sfc_cmd_decode.sv
// Self-checking bench for the serial flash command decoder.
// Pins come from the host model; the bench answers array fetches.
`timescale 1ns/10ps
module test_sfc_cmd_decode;
    // ----
    // Signals
    // ----
    localparam logic [7:0] MK = 8'ha5; // Arbitrary identity value
    localparam logic [7:0] DH = 8'h1c; // Arbitrary identity value
    localparam logic [7:0] DL = 8'h72; // Arbitrary identity value
    localparam logic [7:0] LG = 8'h39; // Arbitrary identity value
    logic ref_clk, rst_b, quad_mode;
    logic [7:0] status_in, security_in, rd_data, b, c, d;
    logic [5:0] seen;
    logic strobe_seen;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    wire cs_b, sclk, host_si, hold_b, si_out, si_oe, so_out, so_oe, rd_req, param_sel;
    wire wr_strobe, write_latch_flag, secure_area, sleeping;
    wire [23:0] mem_addr;
    wire [7:0] wr_data;
    wire [5:0] ev;
    wire si_in = si_oe ? si_out : host_si; // Shared lane level
    sfc_cmd_decode #(.MAKER_CODE(MK), .DEVICE_HI(DH), .DEVICE_LO(DL), .LEGACY_CODE(LG)) u_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .si_in(si_in),
        .hold_b(hold_b), .si_out(si_out), .si_oe(si_oe), .so_out(so_out), .so_oe(so_oe),
        .quad_mode(quad_mode), .status_in(status_in), .security_in(security_in),
        .rd_data(rd_data), .rd_req(rd_req), .param_sel(param_sel), .mem_addr(mem_addr),
        .wr_data(wr_data), .wr_strobe(wr_strobe), .status_write(ev[0]), .page_write(ev[1]),
        .small_region_wipe(ev[2]), .large_region_wipe(ev[3]), .all_wipe(ev[4]),
        .security_lock_write(ev[5]), .write_latch_flag(write_latch_flag),
        .secure_area(secure_area), .sleeping(sleeping));
    sfc_host_model u_host (.ref_clk(ref_clk), .cs_b(cs_b), .sclk(sclk), .host_si(host_si),
        .hold_b(hold_b), .so_out(so_out), .so_oe(so_oe), .si_out(si_out));
    // Array contents
    function automatic logic [7:0] mem(input logic [23:0] a, input logic p);
        return a[7:0] ^ {p, 7'h15};
    endfunction
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Answer fetches next cycle
    always @(negedge ref_clk) begin
        if (rd_req === 1'b1)
            rd_data <= mem(mem_addr, param_sel);
    end
    // Log pulses and bound the run
    always @(posedge ref_clk) begin
        seen <= seen | ev;
        strobe_seen <= strobe_seen | wr_strobe;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            close_out();
        end
    end
    // ----
    // Tasks
    // ----
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_open(input logic [7:0] op, input int n, input logic [31:0] v);
        u_host.open_frame();
        u_host.send(8, op);
        u_host.send(n, v);
    endtask
    task automatic run(input logic [7:0] op, input int n, input logic [31:0] v);
        rd_open(op, n, v);
        u_host.close_frame();
    endtask
    task automatic rd1(input logic [7:0] op, input int n, input logic [31:0] v);
        rd_open(op, n, v);
        u_host.recv(0, b);
        u_host.close_frame();
    endtask
    task automatic t_latch();
        run(8'h06, 0, 0);
        check(write_latch_flag, 1'b1);
        rd1(8'h05, 0, 0);
        check(b, status_in | 8'h02);
        run(8'h04, 0, 0);
        check(write_latch_flag, 1'b0);
        run(8'h06, 1, 0);
        check(write_latch_flag, 1'b0);
        $display("done latch");
    endtask
    task automatic t_ids();
        rd_open(8'h9f, 0, 0);
        u_host.recv(0, b);
        u_host.recv(0, c);
        u_host.recv(0, d);
        u_host.close_frame();
        check({b, c, d}, {MK, DH, DL});
        for (int a = 0; a < 2; a++) begin
            rd_open(8'h90, 24, a);
            u_host.recv(0, b);
            u_host.recv(0, c);
            u_host.close_frame();
            check(a ? {c, b} : {b, c}, {MK, DH});
        end
        $display("done ids");
    endtask
    task automatic t_modes();
        run(8'hb9, 0, 0);
        check(sleeping, 1'b1);
        rd1(8'h05, 0, 0);
        check(b, 8'haa);
        rd1(8'hab, 24, 0);
        check({b, 7'h00, sleeping}, {LG, 8'h00});
        run(8'hb1, 0, 0);
        check(secure_area, 1'b1);
        run(8'hc1, 0, 0);
        check(secure_area, 1'b0);
        rd1(8'h2b, 0, 0);
        check(b, security_in);
        rd1(8'hff, 0, 0);
        check(b, 8'haa);
        rd1(8'h05, 0, 0);
        check(b, status_in);
        $display("done modes");
    endtask
    task automatic t_reads();
        logic [7:0] ops [4] = '{8'h03, 8'h0b, 8'h5a, 8'h3b};
        for (int i = 0; i < 4; i++) begin
            rd_open(ops[i], i ? 32 : 24, 32'h3456fe00 >> (i ? 0 : 8));
            u_host.recv(i == 3, b);
            u_host.recv(i == 3, c);
            check({so_oe, si_oe}, {1'b1, i == 3});
            u_host.close_frame();
            check({b, c}, {mem(24'h3456fe, i == 2), mem(24'h3456ff, i == 2)});
        end
        $display("done reads");
    endtask
    task automatic t_events();
        logic [7:0] ops [8] = '{8'h01, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h02, 8'h2f};
        int bits [8] = '{8, 24, 24, 24, 0, 0, 32, 0};
        int idx [8] = '{0, 2, 3, 3, 4, 4, 1, 5};
        for (int i = 0; i < 8; i++) begin
            seen = 6'h00;
            strobe_seen = 1'b0;
            run(ops[i], bits[i], 32'h0ab0c55e);
            check(seen, 6'h01 << idx[i]);
            check(strobe_seen, idx[i] < 2);
            if (bits[i] == 24)
                check(mem_addr, 24'hb0c55e);
            if (bits[i] == 8)
                check(wr_data, 8'h5e);
        end
        $display("done events");
    endtask
    task automatic t_pause();
        for (int q = 0; q < 2; q++) begin
            quad_mode = q[0];
            run(8'h04, 0, 0);
            u_host.open_frame();
            u_host.send(4, 4'h0);
            u_host.pause(2);
            u_host.resume();
            u_host.send(4, 4'h6);
            u_host.close_frame();
            check(write_latch_flag, !q[0]);
        end
        quad_mode = 1'b0;
        rd_open(8'h05, 0, 0);
        u_host.pause(1);
        check(so_oe, 1'b0);
        u_host.resume();
        u_host.recv(0, b);
        u_host.close_frame();
        check(b, status_in & 8'hfd);
        seen = 6'h00;
        rd_open(8'h20, 24, 0);
        u_host.pause(0);
        u_host.close_frame();
        u_host.resume();
        check(seen, 6'h00);
        $display("done pause");
    endtask
    initial begin
        rst_b = 1'b0;
        quad_mode = 1'b0;
        status_in = 8'h9d;
        security_in = 8'h6b;
        rd_data = 8'h00;
        seen = 6'h00;
        strobe_seen = 1'b0;
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_latch();
        t_ids();
        t_modes();
        t_reads();
        t_events();
        t_pause();
        close_out();
    end
endmodule // test_sfc_cmd_decode
